/* File: design/pcm_pkg.sv */
/*
 * Shared constants and types for the counter array mode and low-byte block:
 * special-function addresses, mode field positions, reset values and the
 * packed carriers for the special-function bus and the module mode byte.
 * Assumes a byte-wide special-function bus with a page selector.
 */
package pcm_pkg;

   // Register page that holds every register of this block
   localparam logic [7:0] SFR_PAGE_CNT = 8'h00;

   // Special-function addresses
   localparam logic [7:0] ADDR_CNT_LO = 8'hF9;
   localparam logic [7:0] ADDR_CNT_HI = 8'hFA;
   localparam logic [7:0] ADDR_MODE_GEN = 8'hDA;
   localparam logic [7:0] ADDR_MODE_WD = 8'hDF;

   // Module count; entry WD_MODULE_IDX is module 5, owned by the watchdog
   localparam int NUM_MODULES = 2;
   localparam int WD_MODULE_IDX = 1;
   localparam logic [NUM_MODULES-1:0][7:0] MODE_ADDR =
      {ADDR_MODE_WD, ADDR_MODE_GEN};
   localparam logic [NUM_MODULES-1:0] MODULE_IS_WD = 2'h2;

   // Mode byte field positions
   localparam int MODE_WIDE_BIT = 7;
   localparam int MODE_CMPEN_BIT = 6;
   localparam int MODE_CAPPOS_BIT = 5;
   localparam int MODE_CAPNEG_BIT = 4;
   localparam int MODE_MATCH_BIT = 3;
   localparam int MODE_TOGGLE_BIT = 2;
   localparam int MODE_WAVE_BIT = 1;
   localparam int MODE_IRQEN_BIT = 0;

   // Reset values
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [15:0] COUNTER_RESET = 16'h0000;
   localparam logic [7:0] SNAP_RESET = 8'h00;
   localparam logic [7:0] RDATA_RESET = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   // Mode byte, bit 7 first
   typedef struct packed {
      logic wideWaveformSelect;
      logic compareEnable;
      logic capturePositive;
      logic captureNegative;
      logic matchEnable;
      logic toggleEnable;
      logic waveformEnable;
      logic flagIrqEnable;
   } pcmMode_t;

   // One special-function bus cycle
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] page;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pcmSfrReq_t;

endpackage : pcm_pkg

/* File: design/pcm_mode_counter.sv */
/*
 * Counter array slice: the shared 16-bit counter with its low-byte access,
 * the high-byte snapshot, and the mode control, output pin and flag of a
 * general capture/compare module and of module 5.
 * Assumes a synchronous special-function bus (one-cycle rd/wr strobes),
 * a counter tick from the clock selector, compare values from outside,
 * and flag clears from the register that software uses for the flags.
 */
//
// Notes on behaviour
// R1: Waveform enable drives PWM on the output pin; width from wide select.
// R2: Wide select set with waveform enabled gives 16-bit waveform.
// R3: Waveform and toggle enables together give frequency output mode.
// R4: Flag interrupt enable at 0 keeps a set flag from requesting.
// R5: Flag interrupt enable at 1 requests an interrupt while flag set.
// R6: Watchdog enable locks module 5 mode register against writes.
// R7: Low byte register is counter bits 7:0, read/write, resets to zero.
// R8: Low byte answers at address 0xF9 on page 0x00.
// R9: Watchdog enable makes software writes to the low byte ignored.
// R10: Toggle enable inverts the output pin on each compare match.
// R11: Match enable sets the module flag on each compare match.
// R12: High byte reads return a snapshot taken when the low byte is read.
// R13: Low byte write loads counter bits 7:0, upper bits kept unless a tick in the same cycle carries into them.
`timescale 1ns/1ns
module pcm_mode_counter (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire pcm_pkg::pcmSfrReq_t sfrReq,
   input wire logic watchdogEnable,
   input wire logic countTick,
   input wire logic [pcm_pkg::NUM_MODULES*16-1:0] compareValue,
   input wire logic [pcm_pkg::NUM_MODULES-1:0] flagClear,
   output logic [7:0] sfrRdata,
   output logic [pcm_pkg::NUM_MODULES-1:0] moduleOutputPin,
   output logic [pcm_pkg::NUM_MODULES-1:0] captureCompareFlag,
   output logic [pcm_pkg::NUM_MODULES-1:0] flagIrqRequest
);

   // Reset release through two flip-flops; assertion stays asynchronous
   logic rstMeta_q;
   logic rstSync_q;
   logic rstN;

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end
      else
      begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   assign rstN = rstSync_q;

   // Bus decode: every register lives on one page only
   logic pageHit;
   logic wrStrobe;
   logic rdStrobe;
   logic cntLoSel;
   logic cntHiSel;
   logic cntLoWr;
   logic cntHiWr;
   logic cntLoRd;
   logic cntHiRd;

   assign pageHit = (sfrReq.page == pcm_pkg::SFR_PAGE_CNT); // see R8
   assign wrStrobe = sfrReq.wr && pageHit && clkEn;
   assign rdStrobe = sfrReq.rd && pageHit && clkEn;
   assign cntLoSel = (sfrReq.addr == pcm_pkg::ADDR_CNT_LO); // see R8
   assign cntHiSel = (sfrReq.addr == pcm_pkg::ADDR_CNT_HI);
   // Watchdog owns the counter, so software writes fall away
   assign cntLoWr = wrStrobe && cntLoSel && !watchdogEnable; // see R9
   assign cntHiWr = wrStrobe && cntHiSel && !watchdogEnable;
   // Reads are never blocked, the watchdog only guards writes
   assign cntLoRd = rdStrobe && cntLoSel;
   assign cntHiRd = rdStrobe && cntHiSel;

   // Shared counter and high-byte snapshot
   logic [15:0] counter_q;
   logic [15:0] counter_d;
   logic [7:0] snapHi_q;
   logic [7:0] snapHi_d;

   // A software byte write wins over a tick in the same cycle for that byte
   always_comb
   begin
      counter_d = counter_q;
      if (countTick)
      begin
         counter_d = 16'(counter_q + 16'h0001);
      end
      if (cntLoWr)
      begin
         counter_d[7:0] = sfrReq.wdata; // see R13
      end
      if (cntHiWr)
      begin
         counter_d[15:8] = sfrReq.wdata;
      end
   end

   // Snapshot moves only on a low-byte read, keeping the two bytes coherent
   assign snapHi_d = cntLoRd ? counter_q[15:8] : snapHi_q; // see R12

   // Counter and snapshot freeze whole while the clock enable is low
   always_ff @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
      begin
         counter_q <= pcm_pkg::COUNTER_RESET; // see R7
         snapHi_q <= pcm_pkg::SNAP_RESET;
      end
      else if (clkEn)
      begin
         counter_q <= counter_d;
         snapHi_q <= snapHi_d;
      end
   end

   // Per-module state collected for the read mux and the outputs
   logic [pcm_pkg::NUM_MODULES-1:0] modeRdHit;
   logic [pcm_pkg::NUM_MODULES-1:0][7:0] modeView;
   logic [pcm_pkg::NUM_MODULES-1:0] pin_q;
   logic [pcm_pkg::NUM_MODULES-1:0] flag_q;
   logic [pcm_pkg::NUM_MODULES-1:0] irq_q;

   genvar gi;
   generate
      for (gi = 0; gi < pcm_pkg::NUM_MODULES; gi++)
      begin : g_module
         pcm_pkg::pcmMode_t mode_q;
         pcm_pkg::pcmMode_t mode_d;
         logic [15:0] cmpVal;
         logic modeSel;
         logic modeLocked;
         logic modeWr;
         logic matchFull;
         logic matchLow;
         logic freqMode;
         logic wide16Mode;
         logic narrowMode;
         logic plainToggle;
         logic flagSet;
         logic pin_d;
         logic flag_d;
         logic irq_d;
         logic pinBit_q;
         logic flagBit_q;
         logic irqBit_q;

         assign cmpVal = compareValue[gi*16 +: 16];
         assign modeSel = (sfrReq.addr == pcm_pkg::MODE_ADDR[gi]);
         // Module 5 serves the watchdog; its mode byte is frozen meanwhile
         assign modeLocked = pcm_pkg::MODULE_IS_WD[gi]
            && watchdogEnable; // see R6
         assign modeWr = wrStrobe && modeSel && !modeLocked; // see R6
         assign mode_d = modeWr ? pcm_pkg::pcmMode_t'(sfrReq.wdata) : mode_q;
         assign modeRdHit[gi] = rdStrobe && modeSel;
         assign modeView[gi] = mode_q;

         // Matches count only on a counter tick, one event per count value
         assign matchFull = countTick && mode_q.compareEnable
            && (counter_q == cmpVal);
         assign matchLow = countTick && mode_q.compareEnable
            && (counter_q[7:0] == cmpVal[7:0]);

         // Mode selection from the waveform, wide and toggle bits; the
         // narrow waveform is plain 8-bit, the 9 to 11-bit widths are absent
         assign freqMode = mode_q.waveformEnable
            && mode_q.toggleEnable; // see R3
         assign wide16Mode = mode_q.waveformEnable && !mode_q.toggleEnable
            && mode_q.wideWaveformSelect; // see R2
         assign narrowMode = mode_q.waveformEnable && !mode_q.toggleEnable
            && !mode_q.wideWaveformSelect; // see R1
         assign plainToggle = !mode_q.waveformEnable && mode_q.toggleEnable;

         // Output pin next level; the comparator enable gates every mode
         always_comb
         begin
            pin_d = pin_q[gi];
            if (!mode_q.compareEnable)
            begin
               pin_d = pin_q[gi];
            end
            else if (freqMode)
            begin
               pin_d = matchLow ? !pin_q[gi] : pin_q[gi]; // see R3
            end
            else if (wide16Mode)
            begin
               pin_d = (counter_q >= cmpVal); // see R1, R2
            end
            else if (narrowMode)
            begin
               pin_d = (counter_q[7:0] >= cmpVal[7:0]); // see R1
            end
            else if (plainToggle)
            begin
               pin_d = matchFull ? !pin_q[gi] : pin_q[gi]; // see R10
            end
         end

         // A match in the clearing cycle still leaves the flag set
         assign flagSet = matchFull && mode_q.matchEnable; // see R11
         assign flag_d = flagSet ? 1'b1
            : (flagClear[gi] ? 1'b0 : flag_q[gi]); // see R11
         // Request follows the flag through the mask
         assign irq_d = flag_d && mode_d.flagIrqEnable; // see R4, R5

         // Mode, pin, flag and request flops of this module
         always_ff @(posedge mclk or negedge rstN)
         begin
            if (!rstN)
            begin
               mode_q <= pcm_pkg::pcmMode_t'(pcm_pkg::MODE_RESET);
               pinBit_q <= 1'b0;
               flagBit_q <= 1'b0;
               irqBit_q <= 1'b0;
            end
            else if (clkEn)
            begin
               mode_q <= mode_d;
               pinBit_q <= pin_d;
               flagBit_q <= flag_d;
               irqBit_q <= irq_d;
            end
         end

         // One driver per vector bit, gathered from the module's own flops
         assign pin_q[gi] = pinBit_q;
         assign flag_q[gi] = flagBit_q;
         assign irq_q[gi] = irqBit_q;
      end
   endgenerate

   // Read data select; unmapped addresses on this page read as zero
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [7:0] modeRdData;
   logic anyModeRd;

   // Pick the mode byte of whichever module the address selects
   always_comb
   begin
      modeRdData = 8'h00;
      anyModeRd = 1'b0;
      for (int m = 0; m < pcm_pkg::NUM_MODULES; m++)
      begin
         if (modeRdHit[m])
         begin
            modeRdData = modeView[m];
            anyModeRd = 1'b1;
         end
      end
   end

   always_comb
   begin
      rdata_d = rdata_q;
      if (cntLoRd)
      begin
         rdata_d = counter_q[7:0]; // see R7
      end
      else if (cntHiRd)
      begin
         rdata_d = snapHi_q; // see R12
      end
      else if (anyModeRd)
      begin
         rdata_d = modeRdData;
      end
      else if (rdStrobe)
      begin
         rdata_d = pcm_pkg::RDATA_UNMAPPED;
      end
   end

   // Read data stays put between reads so software sees a steady byte
   always_ff @(posedge mclk or negedge rstN)
   begin
      if (!rstN)
      begin
         rdata_q <= pcm_pkg::RDATA_RESET;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   // Outputs straight from flip-flops
   assign sfrRdata = rdata_q;
   assign moduleOutputPin = pin_q;
   assign captureCompareFlag = flag_q;
   assign flagIrqRequest = irq_q;

endmodule : pcm_mode_counter

/* File: sim/pcm_mode_counter_monitor.sv */
/* Checker for the counter slice: shadow counter, snapshot and modes.
   Assumes it is bound to pcm_mode_counter and sees only its ports. */
`timescale 1ns/1ns
module pcm_mode_counter_monitor (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic clkEn,
   input wire pcm_pkg::pcmSfrReq_t sfrReq,
   input wire logic watchdogEnable,
   input wire logic countTick,
   input wire logic [pcm_pkg::NUM_MODULES*16-1:0] compareValue,
   input wire logic [pcm_pkg::NUM_MODULES-1:0] flagClear,
   input wire logic [7:0] sfrRdata,
   input wire logic [pcm_pkg::NUM_MODULES-1:0] moduleOutputPin,
   input wire logic [pcm_pkg::NUM_MODULES-1:0] captureCompareFlag,
   input wire logic [pcm_pkg::NUM_MODULES-1:0] flagIrqRequest
);
   logic [15:0] count_q;
   logic [7:0] snap_q;
   pcm_pkg::pcmMode_t m0_q;
   pcm_pkg::pcmMode_t m1_q;
   // Accepted cycles; the watchdog blocks counter and module 5 mode writes but never reads
   wire sel = clkEn && sfrReq.page == pcm_pkg::SFR_PAGE_CNT;
   wire rdOk = sel && sfrReq.rd;
   wire wrFree = sel && sfrReq.wr && !watchdogEnable;
   wire isLo = sfrReq.addr == pcm_pkg::ADDR_CNT_LO;
   wire isHi = sfrReq.addr == pcm_pkg::ADDR_CNT_HI;
   wire [7:0] countLo = count_q[7:0];
   wire pin0 = moduleOutputPin[0];
   wire flag0 = captureCompareFlag[0];
   wire [15:0] countInc = count_q + {15'h0000, countTick};
   wire togHit = countTick && (m0_q.waveformEnable ?
      count_q[7:0] == compareValue[7:0] : count_q == compareValue[15:0]);
   wire pwmHigh = m0_q.wideWaveformSelect ? count_q >= compareValue[15:0] :
      count_q[7:0] >= compareValue[7:0];
   // Shadow state, frozen with the design while the enable is low
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         count_q <= pcm_pkg::COUNTER_RESET;
         snap_q <= pcm_pkg::SNAP_RESET;
         m0_q <= pcm_pkg::MODE_RESET;
         m1_q <= pcm_pkg::MODE_RESET;
      end
      else if (clkEn)
      begin
         count_q <= {wrFree && isHi ? sfrReq.wdata : countInc[15:8],
            wrFree && isLo ? sfrReq.wdata : countInc[7:0]};
         if (rdOk && isLo)
            snap_q <= count_q[15:8];
         if (sel && sfrReq.wr && sfrReq.addr == pcm_pkg::ADDR_MODE_GEN)
            m0_q <= sfrReq.wdata;
         if (wrFree && sfrReq.addr == pcm_pkg::ADDR_MODE_WD)
            m1_q <= sfrReq.wdata;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Reads, and read data that stands between them
   property p_rd_lo;
      rdOk && isLo |=> sfrRdata == $past(countLo);
   endproperty
   a_rd_lo: assert property (p_rd_lo) else $error("low byte");
   property p_rd_hi;
      rdOk && isHi |=> sfrRdata == $past(snap_q);
   endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("snapshot");
   property p_rd_hold;
      !rdOk |=> $stable(sfrRdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
   // Interrupt mask per module, module 5 mode kept by the shadow
   property p_irq;
      flagIrqRequest ==
         (captureCompareFlag & {m1_q.flagIrqEnable, m0_q.flagIrqEnable});
   endproperty
   a_irq: assert property (p_irq) else $error("irq mask");
   // Pin and flag behaviour of the general module
   property p_toggle;
      clkEn && m0_q.compareEnable && m0_q.toggleEnable
         |=> pin0 == ($past(pin0) ^ $past(togHit));
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle");
   property p_pwm;
      clkEn && !countTick && m0_q.compareEnable && m0_q.waveformEnable &&
         !m0_q.toggleEnable |=> pin0 == $past(pwmHigh);
   endproperty
   a_pwm: assert property (p_pwm) else $error("waveform");
   property p_flag_set;
      clkEn && m0_q.compareEnable && m0_q.matchEnable && countTick &&
         count_q == compareValue[15:0] |=> flag0;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag");
   property p_flag_hold;
      flag0 && !flagClear[0] |=> flag0;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("sticky");
endmodule : pcm_mode_counter_monitor

bind pcm_mode_counter pcm_mode_counter_monitor mon (.mclk(mclk),
   .nrst(nrst), .clkEn(clkEn), .sfrReq(sfrReq),
   .watchdogEnable(watchdogEnable), .countTick(countTick),
   .compareValue(compareValue), .flagClear(flagClear), .sfrRdata(sfrRdata),
   .moduleOutputPin(moduleOutputPin), .captureCompareFlag(captureCompareFlag),
   .flagIrqRequest(flagIrqRequest));

/* File: sim/pcm_mode_counter_bench.sv */
/* Bench for the counter slice: register tasks and port checks.
   Assumes the package and the bound checker are compiled first. */
`timescale 1ns/1ns
module pcm_mode_counter_bench;
   localparam logic [7:0] LO = pcm_pkg::ADDR_CNT_LO;
   localparam logic [7:0] HI = pcm_pkg::ADDR_CNT_HI;
   localparam logic [7:0] GEN = pcm_pkg::ADDR_MODE_GEN;
   localparam logic [7:0] WD = pcm_pkg::ADDR_MODE_WD;
   logic mclk = 1'b0;
   logic nrst, clkEn, watchdogEnable, countTick;
   pcm_pkg::pcmSfrReq_t sfrReq;
   logic [31:0] compareValue;
   logic [1:0] flagClear, moduleOutputPin, captureCompareFlag, flagIrqRequest;
   logic [7:0] sfrRdata;
   logic [7:0] pwmMode [4] = '{8'h42, 8'h42, 8'hC2, 8'hC2};
   logic [15:0] pwmCmp [4] = '{16'hFF04, 16'h0010, 16'h0010, 16'hFF04};
   logic [7:0] pwmPin [4] = '{8'h01, 8'h00, 8'h01, 8'h00};
   int errTotal = 0;
   int nChecks = 0;
   int cyc = 0;
   pcm_mode_counter dut (.mclk(mclk), .nrst(nrst), .clkEn(clkEn),
      .sfrReq(sfrReq), .watchdogEnable(watchdogEnable),
      .countTick(countTick), .compareValue(compareValue),
      .flagClear(flagClear), .sfrRdata(sfrRdata),
      .moduleOutputPin(moduleOutputPin),
      .captureCompareFlag(captureCompareFlag),
      .flagIrqRequest(flagIrqRequest));
   always #20 mclk = ~mclk;
   // A hung run is cut well past the 130 or so cycles needed
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 1000)
      begin
         errTotal++;
         closeOut();
      end
   end
   task automatic closeOut;
      $display("checks %0d mismatches %0d", nChecks, errTotal);
      if (errTotal == 0 && nChecks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : closeOut
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] got);
      nChecks++;
      if (got !== e)
      begin
         errTotal++;
         $display("unexpected %s: expected %h seen %h", nm, e, got);
      end
   endtask : chk
   // Strobe raised after one edge, taken at the next, then dropped
   task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      sfrReq <= '{w, !w, pcm_pkg::SFR_PAGE_CNT, a, d};
      @(posedge mclk);
      sfrReq <= '0;
      #1;
   endtask : op
   task automatic rd(input logic [7:0] a, input logic [7:0] e,
      input string nm);
      op(1'b0, a, 8'h00);
      chk(nm, e, sfrRdata);
   endtask : rd
   // New compare value, then n counter steps and time to settle
   task automatic run(input int n, input logic [15:0] cmp);
      @(posedge mclk);
      compareValue[15:0] <= cmp;
      if (n > 0)
      begin
         countTick <= 1'b1;
         repeat (n) @(posedge mclk);
         countTick <= 1'b0;
      end
      repeat (2) @(posedge mclk);
      #1;
   endtask : run
   initial
   begin
      nrst <= 1'b0;
      clkEn <= 1'b1;
      watchdogEnable <= 1'b0;
      countTick <= 1'b0;
      compareValue <= 32'h00000000;
      flagClear <= 2'h0;
      sfrReq <= '0;
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      rd(LO, 8'h00, "low reset");
      rd(8'h80, 8'h00, "unmapped");
      op(1'b1, LO, 8'hA5);
      rd(LO, 8'hA5, "low written");
      $display("test map done");
      @(posedge mclk);
      watchdogEnable <= 1'b1;
      op(1'b1, LO, 8'h3C);
      op(1'b1, WD, 8'h01);
      rd(LO, 8'hA5, "locked low");
      rd(WD, 8'h00, "locked mode");
      @(posedge mclk);
      watchdogEnable <= 1'b0;
      op(1'b1, WD, 8'h01);
      rd(WD, 8'h01, "freed mode");
      $display("test watchdog done");
      op(1'b1, LO, 8'hFE);
      op(1'b1, HI, 8'h12);
      run(3, 16'h0000);
      rd(LO, 8'h01, "carried low");
      op(1'b1, HI, 8'h55);
      rd(HI, 8'h13, "old snapshot");
      rd(LO, 8'h01, "low again");
      rd(HI, 8'h55, "new snapshot");
      $display("test snapshot done");
      @(posedge mclk);
      compareValue[31:16] <= 16'h5502;
      op(1'b1, WD, 8'h49);
      op(1'b1, GEN, 8'h4D);
      run(3, 16'h5503);
      chk("pin flag irq", 8'h07, {5'h00, moduleOutputPin[0],
         captureCompareFlag[0], flagIrqRequest[0]});
      chk("module five", 8'h03, {5'h00, moduleOutputPin[1],
         captureCompareFlag[1], flagIrqRequest[1]});
      @(posedge mclk);
      flagClear <= 2'h1;
      @(posedge mclk);
      flagClear <= 2'h0;
      #1;
      chk("cleared", 8'h04, {5'h00, moduleOutputPin[0],
         captureCompareFlag[0], flagIrqRequest[0]});
      op(1'b1, GEN, 8'h4C);
      run(1, 16'h5504);
      chk("masked", 8'h02, {5'h00, moduleOutputPin[0],
         captureCompareFlag[0], flagIrqRequest[0]});
      $display("test match done");
      for (int i = 0; i < 4; i++)
      begin
         op(1'b1, GEN, pwmMode[i]);
         run(0, pwmCmp[i]);
         chk("waveform", pwmPin[i], {7'h00, moduleOutputPin[0]});
      end
      op(1'b1, GEN, 8'h46);
      run(1, 16'hFF05);
      chk("frequency", 8'h01, {7'h00, moduleOutputPin[0]});
      $display("test waveform done");
      @(posedge mclk);
      clkEn <= 1'b0;
      op(1'b1, LO, 8'h77);
      rd(LO, 8'h55, "frozen read");
      run(2, 16'hFF06);
      @(posedge mclk);
      clkEn <= 1'b1;
      rd(LO, 8'h06, "thawed low");
      chk("frozen pin", 8'h01, {7'h00, moduleOutputPin[0]});
      $display("test freeze done");
      @(posedge mclk);
      nrst <= 1'b0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      repeat (3) @(posedge mclk);
      rd(LO, 8'h00, "low after reset");
      rd(GEN, 8'h00, "mode after reset");
      chk("reset outputs", 8'h00, {5'h00, moduleOutputPin[0],
         captureCompareFlag[0], flagIrqRequest[0]});
      $display("test reset done");
      closeOut();
   end
endmodule : pcm_mode_counter_bench
